// [gpport_pkg.sv]
package gpport_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_DIR_OFF  = 4'h0;   // port_direction
  localparam logic [3:0] REG_FSEL_OFF = 4'h4;   // port_function_select
  localparam logic [3:0] REG_DATA_OFF = 4'h8;   // port_data_latch
  localparam logic [3:0] REG_PIN_OFF  = 4'hC;   // raw synchronised pin levels

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int         PORT_W         = 8;
  localparam logic [7:0] DIR_RST        = 8'h00;
  localparam logic [7:0] FSEL_RST       = 8'h00;
  localparam logic [7:0] DATA_RST       = 8'h00;
  localparam logic [7:0] IMPL_MASK      = 8'hF7;  // bit 3 absent in dir/fsel
  localparam int         RXD_BIT        = 0;
  localparam int         TXD_BIT        = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] fsel;
    logic [7:0] data;
  } gpport_regs_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic       rxd;
  } gpport_pins_t;

endpackage

// [gpport_sync.sv]
`timescale 1ns/1ns
// Two-stage synchroniser for the asynchronous pin inputs
module gpport_sync #(
  parameter int W = 8
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } gpport_sync_t;

  gpport_sync_t st_q;
  gpport_sync_t st_d;

  // ----------------------------------------------------------------
  // Stage one feeds stage two only
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.s2;
endmodule

// [gpport_top.sv]
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module gpport_top
  import gpport_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [3:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Alternate peripheral outputs (pin 1 = serial_transmit_out)
  input  wire logic [7:0]  alt_out_i,
  // Board pins
  input  wire logic [7:0]  pin_i,
  output logic [7:0]       pin_o,
  output logic [7:0]       pin_oe_o,
  output logic             serial_receive_o
);
  import gpport_pkg::*;

  typedef struct packed {
    gpport_regs_t regs;
    gpport_pins_t pins;
    logic         aw_got;
    logic [3:0]   aw_addr;
    logic         w_got;
    logic [7:0]   w_data;
    logic         w_strb0;
    logic         awready;
    logic         wready;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } gpport_state_t;

  gpport_state_t st_q;
  gpport_state_t st_d;
  logic [7:0]    pin_s;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  gpport_sync #(
    .W (PORT_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (pin_i),
    .sync_o    (pin_s)
  );

  // Decode of a mapped word address, shared by read and write paths
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == REG_DIR_OFF) || (a == REG_FSEL_OFF) ||
              (a == REG_DATA_OFF) || (a == REG_PIN_OFF);
  endfunction

  // Data readback mixes live pins and latch per bit direction
  function automatic logic [7:0] data_view(input gpport_regs_t r, input logic [7:0] p);
    data_view = (r.dir & r.data) | (~r.dir & p);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.awready = 1'b0;
    st_d.wready  = 1'b0;
    st_d.arready = 1'b0;

    // Capture address and data independently, in either order
    if (!st_q.aw_got && !st_q.bvalid && s_axi_awvalid_i && !st_q.awready) begin
      st_d.awready = 1'b1;
      st_d.aw_got  = 1'b1;
      st_d.aw_addr = {s_axi_awaddr_i[3:2], 2'b00};
    end
    if (!st_q.w_got && !st_q.bvalid && s_axi_wvalid_i && !st_q.wready) begin
      st_d.wready  = 1'b1;
      st_d.w_got   = 1'b1;
      st_d.w_data  = s_axi_wdata_i[7:0];
      st_d.w_strb0 = s_axi_wstrb_i[0];
    end

    // Commit once both halves are held; only lane 0 carries data
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = addr_ok(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.w_strb0) begin
        case (st_q.aw_addr)
          REG_DIR_OFF:  st_d.regs.dir  = st_q.w_data & IMPL_MASK;
          REG_FSEL_OFF: st_d.regs.fsel = st_q.w_data & IMPL_MASK;
          REG_DATA_OFF: st_d.regs.data = st_q.w_data;
          default: ;
        endcase
      end
    end
    if (st_q.bvalid && s_axi_bready_i) begin
      st_d.bvalid = 1'b0;
    end

    // Read channel: one read in flight
    if (!st_q.rvalid && !st_q.arready && s_axi_arvalid_i) begin
      st_d.arready = 1'b1;
      st_d.rvalid  = 1'b1;
      st_d.rresp   = addr_ok({s_axi_araddr_i[3:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
      case ({s_axi_araddr_i[3:2], 2'b00})
        REG_DIR_OFF:  st_d.rdata = {24'h00_0000, st_q.regs.dir};
        REG_FSEL_OFF: st_d.rdata = {24'h00_0000, st_q.regs.fsel};
        REG_DATA_OFF: st_d.rdata = {24'h00_0000, data_view(st_q.regs, pin_s)};
        REG_PIN_OFF:  st_d.rdata = {24'h00_0000, pin_s};
        default:      st_d.rdata = 32'h0000_0000;
      endcase
    end else if (st_q.rvalid && s_axi_rready_i) begin
      st_d.rvalid = 1'b0;
    end

    // Pin drive: direction gates the driver, select picks the source except on pin 0, which always drives the latch
    st_d.pins.oe  = st_q.regs.dir;
    st_d.pins.out = (st_q.regs.fsel & alt_out_i) |
                    (~st_q.regs.fsel & st_q.regs.data);
    st_d.pins.out[RXD_BIT] = st_q.regs.data[RXD_BIT];
    st_d.pins.rxd = pin_s[RXD_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_q           <= '0;
      st_q.regs.dir  <= DIR_RST;
      st_q.regs.fsel <= FSEL_RST;
      st_q.regs.data <= DATA_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign s_axi_awready_o  = st_q.awready;
  assign s_axi_wready_o   = st_q.wready;
  assign s_axi_bvalid_o   = st_q.bvalid;
  assign s_axi_bresp_o    = st_q.bresp;
  assign s_axi_arready_o  = st_q.arready;
  assign s_axi_rvalid_o   = st_q.rvalid;
  assign s_axi_rdata_o    = st_q.rdata;
  assign s_axi_rresp_o    = st_q.rresp;
  assign pin_o            = st_q.pins.out;
  assign pin_oe_o         = st_q.pins.oe;
  assign serial_receive_o = st_q.pins.rxd;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_OE_FOLLOWS_DIR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $changed(st_q.regs.dir) |=> pin_oe_o == $past(st_q.regs.dir))
    else $error("Output enable does not follow direction");
  AST_DIR_RESET: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> st_q.regs.dir == 8'h00)
    else $error("Direction not cleared by reset");
  AST_ALT_SELECT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.regs.fsel[TXD_BIT] && $stable(st_q.regs.fsel) |=>
      pin_o[TXD_BIT] == $past(alt_out_i[TXD_BIT]))
    else $error("Alternate output not routed");
  AST_FSEL_RESET: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> st_q.regs.fsel == 8'h00)
    else $error("Function select not cleared by reset");
  AST_RXD_PATH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ##3 serial_receive_o == $past(pin_i[RXD_BIT], 3))
    else $error("Receive pin path broken");
  AST_DATA_RESET: assert property (@(posedge sys_clk_i)
    !rst_n_i |=> st_q.regs.data == 8'h00)
    else $error("Data latch not cleared by reset");
  AST_READ_VIEW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    s_axi_arvalid_i && !st_q.rvalid && !st_q.arready &&
      s_axi_araddr_i[3:2] == 2'b10 |=>
      s_axi_rdata_o[7:0] == (($past(st_q.regs.dir) & $past(st_q.regs.data)) |
                             (~$past(st_q.regs.dir) & $past(pin_s))))
    else $error("Data readback mix wrong");
  AST_DATA_WRITE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    st_q.aw_got && st_q.w_got && st_q.w_strb0 && st_q.aw_addr == REG_DATA_OFF |=>
      st_q.regs.data == $past(st_q.w_data) && s_axi_bvalid_o)
    else $error("Data latch write lost");
  AST_BIT3_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !st_q.regs.dir[3] && !st_q.regs.fsel[3] && !pin_oe_o[3])
    else $error("Unimplemented bit 3 set");
endmodule

// [gpport_board.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Board circuitry on the port pins
// ----------------------------------------------------------------
// A driven pin shows the port's own value; a released pin shows the
// external source chosen by the bench, never a held-over port value.
module gpport_board (
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  input  wire logic [7:0] ext_i,
  output logic      [7:0] pin_lvl_o
);
  assign pin_lvl_o = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
endmodule

// [gpport_bench.sv]
`timescale 1ns/1ns
module gpport_bench;
  import gpport_pkg::*;
  logic        sys_clk_i, rst_n_i, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, srx;
  logic [3:0]  awa, ws, ara;
  logic [31:0] wd, rd, r;
  logic [1:0]  bresp, rresp;
  logic [7:0]  alt, pin_i, pin_o, oe, ext;
  int          n_errors, cmp_count, cyc;

  gpport_top dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .alt_out_i(alt), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(oe), .serial_receive_o(srx));
  gpport_board board (.pin_o(pin_o), .pin_oe_o(oe), .ext_i(ext), .pin_lvl_o(pin_i));

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Each half is released at its own handshake; the slave may take them apart
  task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
    bit ad, wdn;
    ad = 0;
    wdn = 0;
    @(posedge sys_clk_i);
    awa <= a; awv <= 1'b1; wd <= {24'h0, d}; ws <= s; wv <= 1'b1; br <= 1'b1;
    while (!(ad && wdn)) begin
      @(posedge sys_clk_i);
      if (awr === 1'b1) begin ad = 1; awv <= 1'b0; end
      if (wr === 1'b1) begin wdn = 1; wv <= 1'b0; end
    end
    do @(posedge sys_clk_i); while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", 32'(bresp), 32'(RESP_OKAY));
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do @(posedge sys_clk_i); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge sys_clk_i);
    d = rd;
    rr <= 1'b0;
    chk("rresp", 32'(rresp), 32'(RESP_OKAY));
  endtask

  // Pin 0 never takes an alternate output, whatever its select bit says
  function automatic logic [7:0] exp_out(input logic [7:0] f, x, a);
    logic [7:0] fe;
    fe = f & IMPL_MASK & 8'hFE;
    return (fe & a) | (~fe & x);
  endfunction

  // Outputs read back the latch, inputs the live pin
  function automatic logic [7:0] exp_rd(input logic [7:0] de, x, e);
    return (de & x) | (~de & e);
  endfunction

  // ----------------------------------------------------------------
  // One configuration, then every port-side consequence of it
  // ----------------------------------------------------------------
  task automatic run(input logic [7:0] d, f, x, e, a);
    logic [7:0] de, lvl;
    de = d & IMPL_MASK;
    axw(REG_DATA_OFF, x, 4'h1);
    axw(REG_FSEL_OFF, f, 4'h1);
    axw(REG_DIR_OFF, d, 4'h1);
    @(posedge sys_clk_i);
    ext <= e; alt <= a;
    repeat (6) @(posedge sys_clk_i);
    lvl = (de & exp_out(f, x, a)) | (~de & e);
    chk("pin_oe", 32'(oe), {24'h0, de});
    chk("pin_out", 32'(pin_o & de), {24'h0, exp_out(f, x, a) & de});
    chk("serial_rx", 32'(srx), 32'(lvl[0]));
    axr(REG_DATA_OFF, r);
    chk("data_rd", r, {24'h0, exp_rd(de, x, e)});
    axr(REG_DIR_OFF, r);
    chk("dir_rd", r, {24'h0, de});
    axr(REG_FSEL_OFF, r);
    chk("fsel_rd", r, {24'h0, f & IMPL_MASK});
    axr(REG_PIN_OFF, r);
    chk("pin_rd", r, {24'h0, lvl});
  endtask

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  // Bounded run: a hang counts as a failure
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    rst_n_i = 1'b0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
    awa = 0; ws = 0; ara = 0; wd = 0; alt = 0; ext = 8'h00;
    void'($urandom(25));
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk("oe_rst", 32'(oe), 32'h0);
    axr(REG_DIR_OFF, r);
    chk("dir_rst", r, {24'h0, DIR_RST});
    axr(REG_FSEL_OFF, r);
    chk("fsel_rst", r, {24'h0, FSEL_RST});
    axr(REG_DATA_OFF, r);
    chk("data_rst", r, {24'h0, DATA_RST});
    // Serial link setup with the transmit line at both levels
    run(8'hC2, 8'h03, 8'h00, 8'h5A, 8'h02);
    run(8'hC2, 8'h03, 8'h00, 8'h5B, 8'hFD);
    run(8'hFF, 8'hFF, 8'hA5, 8'h00, 8'h3C);
    // Latch written while all pins are inputs must show once they drive
    run(8'h00, 8'h00, 8'hB6, 8'h49, 8'h00);
    axw(REG_DIR_OFF, 8'hFF, 4'h1);
    axr(REG_DATA_OFF, r);
    chk("data_keep", r, {24'h0, exp_rd(IMPL_MASK, 8'hB6, 8'h49)});
    // Disabled byte lane leaves the latch alone
    axw(REG_DATA_OFF, 8'h11, 4'h0);
    axr(REG_DATA_OFF, r);
    chk("data_strb", r, {24'h0, exp_rd(IMPL_MASK, 8'hB6, 8'h49)});
    repeat (40) run(8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom));
    stop_test();
  end
endmodule
